// ---- status_pkg.sv ----
// Purpose: Shared constants and carriers for the processor status register block
// Assumes: 32-bit Avalon-MM register bus, 40 MHz sys_clk
// Notes:   Field positions and bus offsets are named once here
package status_pkg;

	localparam int           DATA_W             = 32;
	localparam int           ADDR_W             = 4;
	// Byte addresses of the bus registers
	localparam logic [3:0]   OFS_STATUS         = 4'h0;
	localparam logic [3:0]   OFS_EVENT          = 4'h4;
	localparam logic [3:0]   OFS_QUERY          = 4'h8;
	localparam logic [3:0]   OFS_RESULT         = 4'hC;
	// Field positions in processor_status
	localparam int           POS_COP3           = 31;
	localparam int           POS_COP2           = 30;
	localparam int           POS_COP1           = 29;
	localparam int           POS_COP0           = 28;
	localparam int           POS_FLIP           = 25;
	localparam int           POS_BOOT           = 22;
	localparam int           POS_TLBSD          = 21;
	localparam int           POS_PARF           = 20;
	localparam int           POS_ISOM           = 19;
	localparam int           POS_PZERO          = 18;
	localparam int           POS_SWAP           = 17;
	localparam int           POS_ISOL           = 16;
	localparam int           POS_MASK_LO        = 8;
	localparam int           POS_KU_C           = 1;
	localparam int           POS_IE_C           = 0;
	// Bits that software may write (reserved bits 27:26, 24:23, 7:6 and flag bits 21:19 excluded)
	localparam logic [31:0]  WRITE_MASK         = 32'hF247FF3F;
	// Reset values
	localparam logic [7:0]   RESET_MASK         = 8'h00;
	localparam logic [1:0]   RESET_CUR          = 2'h2;
	localparam logic         RESET_BOOT         = 1'b1;
	localparam logic [31:0]  USER_TOP           = 32'h7FFFFFFF;
	// Bus answers after one wait cycle
	localparam int           WAIT_CYCLES        = 1;

	typedef struct packed {
		logic       kernel;
		logic       int_enable;
	} mode_pair_type;

	typedef struct packed {
		mode_pair_type old_pair;
		mode_pair_type prev_pair;
		mode_pair_type cur_pair;
	} mode_stack_type;

	typedef struct packed {
		logic       exc_take;
		logic       exc_return;
		logic       tlb_double;
		logic       parity_err;
		logic       dcache_miss;
	} event_type;

	function automatic logic [31:0] pack_status(input logic [31:0] fields,
		input mode_stack_type stk);
		pack_status = {fields[31:6], stk};
	endfunction : pack_status

endpackage : status_pkg

// ---- mode_stack.sv ----
// Purpose: Three-deep kernel and interrupt-enable stack
// Assumes: Exception and return never assert with a software write
// Notes:   Exception wins over return if both arrive together
`timescale 1ns/1ps
module mode_stack
	import status_pkg::*;
(
	input  wire logic           sys_clk,
	input  wire logic           rst_n,
	input  wire logic           exc_take,
	input  wire logic           exc_return,
	input  wire logic           sw_write,
	input  wire logic [5:0]     sw_data,
	output mode_stack_type      stack
);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stack <= '{old_pair: '0, prev_pair: '0, cur_pair: RESET_CUR};
		end else if (exc_take) begin
			stack.old_pair  <= stack.prev_pair;
			stack.prev_pair <= stack.cur_pair;
			stack.cur_pair  <= '{kernel: 1'b1, int_enable: 1'b0};
		end else if (exc_return) begin
			stack.cur_pair  <= stack.prev_pair;
			stack.prev_pair <= stack.old_pair;
		end else if (sw_write) begin
			stack <= sw_data;
		end
	end

	chk_push_shift: assert property (@(posedge sys_clk) disable iff (!rst_n)
		exc_take |=> stack.prev_pair == $past(stack.cur_pair)
			&& stack.old_pair == $past(stack.prev_pair))
		else $error("stack push lost a pair");

	chk_pop_old_kept: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(exc_return && !exc_take) |=> stack.old_pair == $past(stack.old_pair)
			&& stack.cur_pair == $past(stack.prev_pair))
		else $error("stack pop wrong");

endmodule : mode_stack

// ---- privilege_check.sv ----
// Purpose: Combines status fields with CPU requests into permission results
// Assumes: Only status and the endian strap are registered in the caller
// Notes:   Results are registered one cycle later by the top module
`timescale 1ns/1ps
module privilege_check
	import status_pkg::*;
(
	input  wire logic [31:0]    status,
	input  wire logic [3:0]     cop_sel,
	input  wire logic           cop_instr,
	input  wire logic [31:0]    prog_addr,
	input  wire logic           priv_instr,
	input  wire logic           reset_big_endian,
	output logic                cop_fault,
	output logic                addr_fault,
	output logic                big_endian
);

	logic kernel;

	always_comb begin
		kernel     = status[POS_KU_C];
		cop_fault  = 1'b0;
		if (cop_instr) begin
			unique case (1'b1)
				cop_sel[3]: cop_fault = !status[POS_COP3];
				cop_sel[2]: cop_fault = !status[POS_COP2];
				cop_sel[1]: cop_fault = !status[POS_COP1];
				cop_sel[0]: cop_fault = !kernel && !status[POS_COP0];
				default:    cop_fault = 1'b0;
			endcase
		end
		addr_fault = !kernel && ((prog_addr > USER_TOP)
			|| (priv_instr && !status[POS_COP0]));
		big_endian = reset_big_endian ^ (!kernel && status[POS_FLIP]);
	end

endmodule : privilege_check

// ---- cpu_status_register.sv ----
// Purpose: Processor status register with mode stack, flags and control decode
// Assumes: Single sys_clk domain; CPU side signals are synchronous to sys_clk
// Notes:   Software also reaches the register over Avalon-MM at OFS_STATUS
//
// Summary of operation
// - Top two bits enable coprocessors 3 and 2; clear means unusable.
// - Coprocessor 1 unusable makes every float unit instruction fault, any mode.
// - Coprocessor 0 always usable in kernel; bit grants it to user.
// - Flip bit reverses reset byte order for user accesses only.
// - Boot select one uses ROM vectors, zero uses RAM vectors.
// - Double TLB match sets shutdown flag, cleared only by reset.
// - Variant without TLB sets shutdown flag at reset.
// - Cache parity error sets fault flag and raises no exception.
// - Data miss while isolated sets the isolated-miss flag.
// - Parity-zero writes zero parity and disables parity checking.
// - Swap and isolate bits are cleared by reset; software sets them.
// - Isolate keeps all loads and stores off the bus; partial stores invalidate.
// - Swap exchanges instruction and data cache roles.
// - Eight mask bits gate six pins and two software interrupts.
// - No priority among pending unmasked interrupts.
// - User mode faults on addresses above user range or denied privileges.
// - Interrupt enable zero blocks all interrupts.
// - Exception pushes the mode stack and forces kernel, interrupts off.
// - Return from exception pops the mode stack.
// - Reserved zero bits read zero; software writes zero.
`timescale 1ns/1ps
module cpu_status_register
	import status_pkg::*;
#(
	parameter bit             HAS_TLB        = 1'b1,
	parameter logic [31:0]    ROM_VECTOR     = 32'hBFC00180,
	parameter logic [31:0]    RAM_VECTOR     = 32'h80000080
)
(
	input  wire logic                 sys_clk,
	input  wire logic                 rst_n,
	input  wire logic [ADDR_W-1:0]    avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [DATA_W-1:0]    avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output logic [DATA_W-1:0]         avs_readdata,
	output logic                      avs_waitrequest,
	input  wire event_type            events,
	input  wire logic [5:0]           int_pins,
	input  wire logic [1:0]           soft_int,
	input  wire logic [3:0]           cop_sel,
	input  wire logic                 cop_instr,
	input  wire logic [31:0]          prog_addr,
	input  wire logic                 priv_instr,
	input  wire logic                 reset_big_endian,
	input  wire logic                 dcache_partial_store,
	output logic                      cop_fault,
	output logic                      addr_fault,
	output logic                      big_endian,
	output logic [7:0]                int_pending,
	output logic                      int_request,
	output logic [31:0]               exc_vector,
	output logic                      parity_write_zero,
	output logic                      parity_check_en,
	output logic                      bus_block,
	output logic                      cache_swap_out,
	output logic                      dcache_invalidate
);

	logic [31:0]      fields;
	mode_stack_type   stack;
	logic [31:0]      status;
	logic             bus_pending;
	logic             bus_accept;
	logic             sw_write;
	logic [31:0]      next_fields;
	logic [31:0]      byte_mask;
	logic             comb_cop_fault;
	logic             comb_addr_fault;
	logic             comb_big_endian;
	logic             reset_strap_done;
	logic             tlb_dbl_q1;
	logic             tlb_dbl_q2;
	logic [5:0]       int_pins_q1;
	logic [5:0]       int_pins_q2;
	logic             endian_q1;
	logic             endian_q2;
	logic [7:0]       masked_ints;

	assign status = pack_status(fields, stack);

	// Interrupt pins and the endian strap come from the board, not from sys_clk logic
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			int_pins_q1 <= '0;
			int_pins_q2 <= '0;
			endian_q1   <= 1'b0;
			endian_q2   <= 1'b0;
		end else begin
			int_pins_q1 <= int_pins;
			int_pins_q2 <= int_pins_q1;
			endian_q1   <= reset_big_endian;
			endian_q2   <= endian_q1;
		end
	end

	// One shared view of unmasked sources keeps pending and request consistent
	assign masked_ints = {int_pins_q2, soft_int} & fields[15:8];

	// Bus: one wait cycle so every answer is registered
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_pending <= 1'b0;
		end else begin
			bus_pending <= (avs_read || avs_write) && !bus_pending;
		end
	end

	assign bus_accept = bus_pending && (avs_read || avs_write);
	assign sw_write   = bus_accept && avs_write && avs_address == OFS_STATUS;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && !bus_pending);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (avs_read && !bus_pending) begin
			unique case (avs_address)
				OFS_STATUS: avs_readdata <= status & WRITE_MASK | (status & 32'h00380000);
				OFS_RESULT: avs_readdata <= {29'h0, comb_big_endian, comb_addr_fault,
					comb_cop_fault};
				default:    avs_readdata <= '0;
			endcase
		end
	end

	always_comb begin
		byte_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
			{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}} & WRITE_MASK;
		next_fields = (fields & ~byte_mask) | (avs_writedata & byte_mask);
	end

	// Double-match event crosses from TLB logic on a pin-style path
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			tlb_dbl_q1 <= 1'b0;
			tlb_dbl_q2 <= 1'b0;
		end else begin
			tlb_dbl_q1 <= events.tlb_double;
			tlb_dbl_q2 <= tlb_dbl_q1;
		end
	end

	// Software writable fields; swap and isolate start at zero as the safe choice
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			fields                    <= '0;
			fields[POS_BOOT]          <= RESET_BOOT;
			fields[15:8]              <= RESET_MASK;
		end else begin
			if (sw_write) begin
				fields[31:22]        <= next_fields[31:22];
				fields[18:6]         <= next_fields[18:6];
			end
			// Hardware sets win over any software write
			if (tlb_dbl_q2 || (!HAS_TLB && !reset_strap_done)) begin
				fields[POS_TLBSD]    <= 1'b1;
			end
			if (sw_write && !events.parity_err) begin
				fields[POS_PARF]     <= next_fields[POS_PARF];
			end else if (events.parity_err && !fields[POS_PZERO]) begin
				fields[POS_PARF]     <= 1'b1;
			end
			if (sw_write && !(events.dcache_miss && fields[POS_ISOL])) begin
				fields[POS_ISOM]     <= next_fields[POS_ISOM];
			end else if (events.dcache_miss && fields[POS_ISOL]) begin
				fields[POS_ISOM]     <= 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reset_strap_done <= 1'b0;
		end else begin
			reset_strap_done <= 1'b1;
		end
	end

	mode_stack u_stack (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.exc_take   (events.exc_take),
		.exc_return (events.exc_return),
		.sw_write   (sw_write),
		.sw_data    (next_fields[5:0]),
		.stack      (stack)
	);

	privilege_check u_check (
		.status           (status),
		.cop_sel          (cop_sel),
		.cop_instr        (cop_instr),
		.prog_addr        (prog_addr),
		.priv_instr       (priv_instr),
		.reset_big_endian (endian_q2),
		.cop_fault        (comb_cop_fault),
		.addr_fault       (comb_addr_fault),
		.big_endian       (comb_big_endian)
	);

	// Registered controls to the core
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cop_fault         <= 1'b0;
			addr_fault        <= 1'b0;
			big_endian        <= 1'b0;
			int_pending       <= '0;
			int_request       <= 1'b0;
			exc_vector        <= ROM_VECTOR;
			parity_write_zero <= 1'b0;
			parity_check_en   <= 1'b1;
			bus_block         <= 1'b0;
			cache_swap_out    <= 1'b0;
			dcache_invalidate <= 1'b0;
		end else begin
			cop_fault         <= comb_cop_fault;
			addr_fault        <= comb_addr_fault;
			big_endian        <= comb_big_endian;
			// Every unmasked source shown flat; software picks the order
			int_pending       <= masked_ints;
			int_request       <= stack.cur_pair.int_enable && |masked_ints;
			exc_vector        <= fields[POS_BOOT] ? ROM_VECTOR : RAM_VECTOR;
			parity_write_zero <= fields[POS_PZERO];
			parity_check_en   <= !fields[POS_PZERO];
			bus_block         <= fields[POS_ISOL];
			cache_swap_out    <= fields[POS_SWAP];
			dcache_invalidate <= fields[POS_ISOL] && dcache_partial_store;
		end
	end

	chk_tlb_sticky: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fields[POS_TLBSD] |=> fields[POS_TLBSD])
		else $error("tlb shutdown flag cleared without reset");

	// Double match passes two flops before it reaches the flag
	chk_tlb_set: assert property (@(posedge sys_clk) disable iff (!rst_n)
		events.tlb_double |-> ##3 fields[POS_TLBSD])
		else $error("double match did not set shutdown");

	chk_int_gate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!stack.cur_pair.int_enable |=> !int_request)
		else $error("interrupt requested while disabled");

	chk_request_pend: assert property (@(posedge sys_clk) disable iff (!rst_n)
		int_request |-> int_pending != 8'h00)
		else $error("request without a pending source");

	chk_pending_mask: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> (int_pending & ~$past(fields[15:8])) == 8'h00)
		else $error("masked source shown pending");

	chk_exc_kernel: assert property (@(posedge sys_clk) disable iff (!rst_n)
		events.exc_take |=> stack.cur_pair.kernel && !stack.cur_pair.int_enable)
		else $error("exception did not force kernel mode");

	chk_sw_update: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(sw_write && !events.exc_take && !events.exc_return) |=> stack == $past(next_fields[5:0])
			&& fields[31:22] == $past(next_fields[31:22]))
		else $error("software write not applied at once");

	chk_vector_sel: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fields[POS_BOOT] |=> exc_vector == ROM_VECTOR)
		else $error("boot vector not selected");

	chk_vector_ram: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!fields[POS_BOOT] |=> exc_vector == RAM_VECTOR)
		else $error("ram vector not selected");

	chk_isolate_bus: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fields[POS_ISOL] |=> bus_block)
		else $error("isolate did not block bus");

	chk_invalidate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fields[POS_ISOL] && dcache_partial_store |=> dcache_invalidate)
		else $error("partial store did not invalidate");

	chk_swap_out: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fields[POS_SWAP] |=> cache_swap_out)
		else $error("cache swap not applied");

	chk_miss_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		events.dcache_miss && fields[POS_ISOL] |=> fields[POS_ISOM])
		else $error("isolated miss not flagged");

	chk_miss_cause: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(fields[POS_ISOM]) |-> $past(fields[POS_ISOL]))
		else $error("miss flag set without isolate");

	chk_parity_flag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		events.parity_err && !fields[POS_PZERO] |=> fields[POS_PARF])
		else $error("parity error not flagged");

	chk_reserved_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(status & ~(WRITE_MASK | 32'h00380000)) == 32'h0)
		else $error("reserved bit set");

	chk_parity_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fields[POS_PZERO] |=> !parity_check_en && parity_write_zero)
		else $error("parity zero not applied");

	chk_parity_quiet: assert property (@(posedge sys_clk) disable iff (!rst_n)
		fields[POS_PZERO] && !fields[POS_PARF] |=> !fields[POS_PARF])
		else $error("parity checked while disabled");

	chk_cop1_fault: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cop_instr && cop_sel == 4'h2 && !status[POS_COP1] |=> cop_fault)
		else $error("float instruction not refused");

	chk_cop0_kernel: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cop_instr && cop_sel == 4'h1 && status[POS_KU_C] |=> !cop_fault)
		else $error("kernel refused coprocessor 0");

	chk_user_range: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!status[POS_KU_C] && prog_addr > USER_TOP |=> addr_fault)
		else $error("user access above range allowed");

	// Kernel accesses keep the strap order whatever the flip bit holds
	chk_kernel_order: assert property (@(posedge sys_clk) disable iff (!rst_n)
		status[POS_KU_C] |=> big_endian == $past(endian_q2))
		else $error("kernel byte order flipped");

	chk_wait_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
		$rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("bus answer not after one wait cycle");

	chk_wait_single: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low for more than one cycle");

endmodule : cpu_status_register

// ---- test_cpu_status_register.sv ----
// Purpose: Self-checking bench for cpu_status_register
// Assumes: Avalon-MM slave with waitrequest; CPU-side outputs registered one cycle
// Notes:   TLB-less build not covered here; it would need a second instance
`timescale 1ns/1ps
module test_cpu_status_register
	import status_pkg::*;
;
	localparam logic [31:0] ROM_V = 32'h1FC00180;
	localparam logic [31:0] RAM_V = 32'h00000080;

	logic              sys_clk;
	logic              rst_n;
	logic [3:0]        avs_address;
	logic              avs_read;
	logic              avs_write;
	logic [31:0]       avs_writedata;
	logic [3:0]        avs_byteenable;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	event_type         events;
	logic [5:0]        int_pins;
	logic [1:0]        soft_int;
	logic [3:0]        cop_sel;
	logic [31:0]       prog_addr;
	logic              priv_instr;
	logic              cop_instr;
	logic              reset_big_endian;
	logic              dcache_partial_store;
	logic              cop_fault;
	logic              addr_fault;
	logic              big_endian;
	logic [7:0]        int_pending;
	logic              int_request;
	logic [31:0]       exc_vector;
	logic              parity_write_zero;
	logic              parity_check_en;
	logic              bus_block;
	logic              cache_swap_out;
	logic              dcache_invalidate;
	int                err_total;
	int                n_tests;

	cpu_status_register #(.HAS_TLB(1'b1), .ROM_VECTOR(ROM_V), .RAM_VECTOR(RAM_V)) uut (
		.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .events(events), .int_pins(int_pins),
		.soft_int(soft_int), .cop_sel(cop_sel), .cop_instr(cop_instr), .prog_addr(prog_addr),
		.priv_instr(priv_instr), .reset_big_endian(reset_big_endian),
		.dcache_partial_store(dcache_partial_store), .cop_fault(cop_fault),
		.addr_fault(addr_fault), .big_endian(big_endian), .int_pending(int_pending),
		.int_request(int_request), .exc_vector(exc_vector),
		.parity_write_zero(parity_write_zero), .parity_check_en(parity_check_en),
		.bus_block(bus_block), .cache_swap_out(cache_swap_out),
		.dcache_invalidate(dcache_invalidate));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
			err_total++;
		end
	endtask : chk

	// Request held until waitrequest is sampled low; only the watchdog ends a wait
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask : bus

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string what);
		logic [31:0] q;
		bus(1'b0, a, 32'h00000000, q);
		chk(q, exp, what);
	endtask : rd

	// Pin synchroniser plus output register: four edges cover the slowest path
	task automatic settle;
		repeat (4) @(posedge sys_clk);
	endtask : settle

	task automatic pulse(input event_type e);
		@(posedge sys_clk);
		events <= e;
		@(posedge sys_clk);
		events <= '0;
	endtask : pulse

	task automatic do_reset;
		rst_n <= 1'b0;
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
	endtask : do_reset

	// Result bits: {big_endian, addr_fault, cop_fault}
	task automatic prv(input logic [31:0] st, input logic [3:0] sel, input logic [31:0] pa,
		input logic [2:0] exp);
		wr(OFS_STATUS, st);
		cop_sel <= sel;
		prog_addr <= pa;
		settle;
		chk({29'h0, big_endian, addr_fault, cop_fault}, {29'h0, exp}, "privilege");
	endtask : prv

	initial begin
		repeat (20000) @(posedge sys_clk);
		$display("BAD t=%0t watchdog expired", $time);
		err_total++;
		wrap_up;
	end

	initial begin
		err_total = 0;
		n_tests = 0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h00000000;
		avs_byteenable = 4'hF;
		events = '0;
		int_pins = 6'h00;
		soft_int = 2'h0;
		cop_sel = 4'h0;
		prog_addr = 32'h00000000;
		priv_instr = 1'b0;
		cop_instr = 1'b1;
		reset_big_endian = 1'b1;
		dcache_partial_store = 1'b0;
		do_reset;
		chk(exc_vector, ROM_V, "boot vector after reset");
		rd(OFS_STATUS, 32'h00400002, "status reset value");
		rd(OFS_EVENT, 32'h00000000, "unmapped read");
		wr(OFS_STATUS, 32'hFFFFFFFF);
		rd(OFS_STATUS, 32'hF247FF3F, "reserved and flag bits");
		wr(OFS_STATUS, 32'h00000000);
		rd(OFS_STATUS, 32'h00000000, "all fields cleared");
		settle;
		chk(exc_vector, RAM_V, "ram vectors");
		// Mode stack push then pop
		wr(OFS_STATUS, 32'h00000019);
		pulse('{exc_take: 1'b1, default: 1'b0});
		rd(OFS_STATUS, 32'h00000026, "stack push");
		pulse('{exc_return: 1'b1, default: 1'b0});
		rd(OFS_STATUS, 32'h00000029, "stack pop");
		// Interrupt gating
		int_pins <= 6'h01;
		wr(OFS_STATUS, 32'h00000403);
		settle;
		chk({24'h0, int_pending}, 32'h00000004, "pin pending");
		chk({31'h0, int_request}, 32'h00000001, "request");
		int_pins <= 6'h00;
		soft_int <= 2'h2;
		settle;
		chk({31'h0, int_request}, 32'h00000000, "masked soft");
		int_pins <= 6'h3F;
		soft_int <= 2'h3;
		wr(OFS_STATUS, 32'h0000FF02);
		settle;
		chk({24'h0, int_pending}, 32'h000000FF, "all pending");
		chk({31'h0, int_request}, 32'h00000000, "enable off");
		// Diagnostic flags with isolate set
		wr(OFS_STATUS, 32'h00010002);
		dcache_partial_store <= 1'b1;
		settle;
		chk({30'h0, bus_block, parity_check_en}, 32'h00000003, "isolate");
		chk({31'h0, dcache_invalidate}, 32'h00000001, "partial store");
		dcache_partial_store <= 1'b0;
		pulse('{parity_err: 1'b1, default: 1'b0});
		pulse('{dcache_miss: 1'b1, default: 1'b0});
		pulse('{tlb_double: 1'b1, default: 1'b0});
		settle;
		rd(OFS_STATUS, 32'h00390002, "flags set");
		wr(OFS_STATUS, 32'h00060002);
		rd(OFS_STATUS, 32'h003E0002, "flags survive write");
		chk({30'h0, parity_write_zero, parity_check_en}, 32'h00000002, "parity zero");
		chk({31'h0, cache_swap_out}, 32'h00000001, "cache swap");
		chk({31'h0, bus_block}, 32'h00000000, "isolate off");
		// Privilege decode
		prv(32'h00000002, 4'h2, 32'h00000000, 3'b101);
		prv(32'h20000000, 4'h2, 32'h00000000, 3'b100);
		prv(32'h00000002, 4'h1, 32'h00000000, 3'b100);
		prv(32'h00000000, 4'h1, 32'h00000000, 3'b101);
		prv(32'h10000000, 4'h1, 32'h00000000, 3'b100);
		prv(32'h00000002, 4'h8, 32'h00000000, 3'b101);
		prv(32'h80000002, 4'h8, 32'h00000000, 3'b100);
		prv(32'h40000002, 4'h4, 32'h00000000, 3'b100);
		prv(32'h22000000, 4'h2, 32'h00000000, 3'b000);
		prv(32'h22000002, 4'h2, 32'h00000000, 3'b100);
		prv(32'h20000000, 4'h2, 32'h80000000, 3'b110);
		prv(32'h20000000, 4'h2, 32'h7FFFFFFF, 3'b100);
		prv(32'h20000002, 4'h2, 32'hFFFFFFFF, 3'b100);
		priv_instr <= 1'b1;
		prv(32'h00000000, 4'h2, 32'h00000000, 3'b111);
		rd(OFS_RESULT, 32'h00000007, "result register");
		prv(32'h30000000, 4'h2, 32'h00000000, 3'b100);
		priv_instr <= 1'b0;
		cop_instr <= 1'b0;
		reset_big_endian <= 1'b0;
		prv(32'h02000000, 4'h2, 32'h00000000, 3'b100);
		prv(32'h02000002, 4'h2, 32'h00000000, 3'b000);
		// Only a hardware reset clears shutdown
		do_reset;
		rd(OFS_STATUS, 32'h00400002, "reset clears shutdown");
		wrap_up;
	end
endmodule : test_cpu_status_register
